//--- pso_regs.svh
// Register indices, field positions, operation codes, stack frame and firmware constants of the privileged operation unit.
`ifndef PSO_REGS_SVH
`define PSO_REGS_SVH

// ----------------------------------------------------------------------------
// Register window: 64-bit items, index in paddr[7:3], upper half at paddr[2]
// ----------------------------------------------------------------------------
`define PSO_IDX_CTRL      5'h00
`define PSO_IDX_PS        5'h01
`define PSO_IDX_SP        5'h02
`define PSO_IDX_USP       5'h03
`define PSO_IDX_KSP       5'h04
`define PSO_IDX_CONTROL_BLOCK_BASE      5'h05
`define PSO_IDX_PAGE_TABLE_BASE      5'h06
`define PSO_IDX_PCC       5'h07
`define PSO_IDX_FEN       5'h08
`define PSO_IDX_UNIQ      5'h09
`define PSO_IDX_ASN       5'h0A
`define PSO_IDX_MACHINE_CHECK_SUMMARY      5'h0B
`define PSO_IDX_SYSVAL    5'h0C
`define PSO_IDX_A0        5'h0D
`define PSO_IDX_A1        5'h0E
`define PSO_IDX_A2        5'h0F
`define PSO_IDX_GP        5'h10
`define PSO_IDX_V0        5'h11
`define PSO_IDX_PC        5'h12
`define PSO_IDX_FWLD      5'h13
`define PSO_IDX_LAST      5'h13

// ----------------------------------------------------------------------------
// Fields and operation codes
// ----------------------------------------------------------------------------
`define PSO_PS_MODE_BIT   3
`define PSO_PS_USER_RET   64'h0000000000000008
`define PSO_CTRL_CLR_BIT  8
`define PSO_OP_NONE       8'h00
`define PSO_OP_CFLUSH     8'h01
`define PSO_OP_CSERVE     8'h02
`define PSO_OP_RDMCES     8'h03
`define PSO_OP_RDPS       8'h04
`define PSO_OP_RDUSP      8'h05
`define PSO_OP_RDVAL      8'h06
`define PSO_OP_RETSYS     8'h07
`define PSO_OP_RTI        8'h08
`define PSO_OP_SWPCTX     8'h09
`define PSO_OP_SWPIPL     8'h0A
`define PSO_OP_SWPPAL     8'h0B

// ----------------------------------------------------------------------------
// Stack frame, firmware variants, options
// ----------------------------------------------------------------------------
`define PSO_FRAME_BYTES   64'h0000000000000030
`define PSO_STACK_MAX_IDX 6'h3A
`define PSO_FW_ID_LIMIT   64'h0000000000000100
`define PSO_FW_VARIANTS   64'h0000000000000008
`define PSO_FW_BASE_SHIFT 16
`define PSO_ASN_IMPL      1'b1
`define PSO_UNIQ_IMPL     1'b1

`endif

//--- pso_pkg.sv
// Types shared by the privileged operation unit and its bench.
package pso_pkg;

  typedef enum logic [1:0] {PSO_IDLE, PSO_RUN, PSO_HALT} pso_state_e;

  typedef struct packed {
    logic opfault;
    logic dcache_page_flush;
    logic console_service;
    logic tb_inval_nonglobal;
    logic tb_inval_all;
    logic icache_flush;
    logic fw_transfer;
  } pso_events_s;

endpackage

//--- pso_privileged_state_ops.sv
// Privileged state operation unit: architectural state, stack memory and operation sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "pso_regs.svh"

module pso_privileged_state_ops (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               irq_pin,
  input  wire logic               mem_only_backup,
  input  wire logic               lock_set,
  output var pso_pkg::pso_events_s events,
  output logic      [63:0]        event_addr,
  output logic                    halted
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  pso_pkg::pso_state_e state_q;
  logic [3:0]  step_q;
  logic [7:0]  op_q;
  logic [63:0] arch_q [1:`PSO_IDX_LAST];
  logic [63:0] mem_q [0:63];
  logic [63:0] tmp_ps_q, tmp_pc_q, old_page_table_base_q;
  logic [31:0] cc_lo_q, tmp_cc_q;
  logic        irq_meta_q, irq_sync_q, bkp_meta_q, bkp_sync_q;
  logic        pend_intr_q, lock_q, fault_q;

  logic [63:0] ps, sp, a0, control_block_base, mem_rd, fw_target;
  logic [5:0]  sp_idx, pc_idx, rd_idx, rd_off;
  logic [4:0]  idx;
  logic [3:0]  last_step;
  logic [1:0]  fw_status;
  logic        mapped, apb_wr, cmd_wr, user_mode, kstack_ok, fin, start_ok;

  assign ps        = arch_q[`PSO_IDX_PS];
  assign sp        = arch_q[`PSO_IDX_SP];
  assign a0        = arch_q[`PSO_IDX_A0];
  assign control_block_base      = arch_q[`PSO_IDX_CONTROL_BLOCK_BASE];
  assign sp_idx    = sp[8:3];
  assign pc_idx    = control_block_base[8:3];
  assign user_mode = ps[`PSO_PS_MODE_BIT];
  assign idx       = paddr[7:3];
  assign mapped    = paddr[11] ? (paddr[10:9] == 2'h0)
                               : (paddr[10:8] == 3'h0 && idx <= `PSO_IDX_LAST);
  assign apb_wr    = psel && penable && pready && pwrite && mapped;
  assign cmd_wr    = apb_wr && !paddr[11] && idx == `PSO_IDX_CTRL && state_q == pso_pkg::PSO_IDLE;
  // Frame must be aligned and lie wholly inside the stack memory.
  assign kstack_ok = sp[63:9] == 55'h0 && sp[2:0] == 3'h0 && sp_idx <= `PSO_STACK_MAX_IDX;
  assign start_ok  = cmd_wr && !user_mode && pwdata[7:0] != `PSO_OP_NONE
                     && pwdata[7:0] <= `PSO_OP_SWPPAL;
  assign fin       = state_q == pso_pkg::PSO_RUN && step_q == last_step;
  assign mem_rd    = mem_q[rd_idx];

  // --------------------------------------------------------------------------
  // Sequencing helpers
  // --------------------------------------------------------------------------
  always_comb begin
    last_step = 4'h0;
    rd_off    = step_q[3:0] == 4'h0 ? 6'h0 : {2'h0, step_q};
    rd_idx    = sp_idx + rd_off;
    case (op_q)
      `PSO_OP_RTI: begin
        last_step = 4'h6;
      end
      `PSO_OP_RETSYS: begin
        last_step = 4'h1;
        rd_idx    = sp_idx + {2'h0, step_q} + 6'h1;
      end
      `PSO_OP_SWPCTX: begin
        last_step = 4'h9;
        case (step_q)
          4'h5:    rd_off = 6'h1;
          4'h6:    rd_off = 6'h2;
          4'h7:    rd_off = 6'h3;
          4'h8:    rd_off = 6'h5;
          4'h9:    rd_off = 6'h4;
          default: rd_off = 6'h0;
        endcase
        rd_idx = pc_idx + rd_off;
      end
      default: begin
        last_step = 4'h0;
      end
    endcase
  end

  // Identifiers below the limit name a variant; anything else is a base address.
  always_comb begin
    fw_status = 2'h0;
    fw_target = a0;
    if (a0 < `PSO_FW_ID_LIMIT) begin
      fw_target = a0 << `PSO_FW_BASE_SHIFT;
      if (a0 >= `PSO_FW_VARIANTS) begin
        fw_status = 2'h1;
      end else if (!arch_q[`PSO_IDX_FWLD][a0[2:0]]) begin
        fw_status = 2'h2;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Operation sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pso_pkg::PSO_IDLE;
      step_q  <= 4'h0;
      op_q    <= `PSO_OP_NONE;
    end else begin
      case (state_q)
        pso_pkg::PSO_IDLE: begin
          step_q <= 4'h0;
          if (cmd_wr) begin
            op_q <= pwdata[7:0];
          end
          if (start_ok) begin
            state_q <= pso_pkg::PSO_RUN;
          end
        end
        pso_pkg::PSO_RUN: begin
          if ((op_q == `PSO_OP_RTI || op_q == `PSO_OP_RETSYS) && step_q == 4'h0 && !kstack_ok) begin
            state_q <= pso_pkg::PSO_HALT;
          end else if (fin) begin
            state_q <= pso_pkg::PSO_IDLE;
          end else begin
            step_q <= step_q + 4'h1;
          end
        end
        pso_pkg::PSO_HALT: begin
          state_q <= pso_pkg::PSO_HALT;
        end
        default: begin
          state_q <= pso_pkg::PSO_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Architectural state
  // --------------------------------------------------------------------------
  // Bus writes and sequencer updates never meet: the bus is held off while an
  // operation runs, so no handler can see a half-finished update.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 1; i <= `PSO_IDX_LAST; i++) begin
        arch_q[i] <= 64'h0;
      end
      tmp_ps_q   <= 64'h0;
      tmp_pc_q   <= 64'h0;
      old_page_table_base_q <= 64'h0;
      tmp_cc_q   <= 32'h0;
    end else if (apb_wr && !paddr[11] && idx != `PSO_IDX_CTRL) begin
      if (paddr[2]) begin
        arch_q[idx] <= idx == `PSO_IDX_PCC ? {32'h0, pwdata} : {pwdata, arch_q[idx][31:0]};
      end else begin
        arch_q[idx] <= idx == `PSO_IDX_PCC ? arch_q[idx] : {arch_q[idx][63:32], pwdata};
      end
    end else if (state_q == pso_pkg::PSO_RUN && kstack_ok | (op_q != `PSO_OP_RTI
                 && op_q != `PSO_OP_RETSYS)) begin
      case (op_q)
        `PSO_OP_RDMCES: arch_q[`PSO_IDX_V0] <= arch_q[`PSO_IDX_MACHINE_CHECK_SUMMARY];
        `PSO_OP_RDPS:   arch_q[`PSO_IDX_V0] <= ps;
        `PSO_OP_RDUSP:  arch_q[`PSO_IDX_V0] <= arch_q[`PSO_IDX_USP];
        `PSO_OP_RDVAL:  arch_q[`PSO_IDX_V0] <= arch_q[`PSO_IDX_SYSVAL];
        `PSO_OP_SWPIPL: begin
          arch_q[`PSO_IDX_V0] <= {61'h0, ps[2:0]};
          arch_q[`PSO_IDX_PS] <= {ps[63:3], a0[2:0]};
        end
        `PSO_OP_SWPPAL: begin
          arch_q[`PSO_IDX_V0] <= {62'h0, fw_status};
          if (fw_status == 2'h0) begin
            arch_q[`PSO_IDX_PC] <= fw_target;
          end
        end
        `PSO_OP_RETSYS: begin
          if (step_q == 4'h0) begin
            tmp_pc_q <= mem_rd;
          end else begin
            arch_q[`PSO_IDX_GP]  <= mem_rd;
            arch_q[`PSO_IDX_KSP] <= sp + `PSO_FRAME_BYTES;
            arch_q[`PSO_IDX_SP]  <= arch_q[`PSO_IDX_USP];
            arch_q[`PSO_IDX_PS]  <= `PSO_PS_USER_RET;
            arch_q[`PSO_IDX_PC]  <= tmp_pc_q;
          end
        end
        `PSO_OP_RTI: begin
          case (step_q)
            4'h0: tmp_ps_q <= mem_rd;
            4'h1: tmp_pc_q <= mem_rd;
            4'h2: arch_q[`PSO_IDX_GP] <= mem_rd;
            4'h3: arch_q[`PSO_IDX_A0] <= mem_rd;
            4'h4: arch_q[`PSO_IDX_A1] <= mem_rd;
            4'h5: arch_q[`PSO_IDX_A2] <= mem_rd;
            default: begin
              arch_q[`PSO_IDX_PC] <= tmp_pc_q;
              if (tmp_ps_q[`PSO_PS_MODE_BIT]) begin
                arch_q[`PSO_IDX_KSP] <= sp + `PSO_FRAME_BYTES;
                arch_q[`PSO_IDX_SP]  <= arch_q[`PSO_IDX_USP];
                arch_q[`PSO_IDX_PS]  <= `PSO_PS_USER_RET;
              end else begin
                arch_q[`PSO_IDX_SP] <= sp + `PSO_FRAME_BYTES;
                arch_q[`PSO_IDX_PS] <= {60'h0, tmp_ps_q[3:0]};
              end
            end
          endcase
        end
        `PSO_OP_SWPCTX: begin
          case (step_q)
            4'h2: tmp_cc_q <= cc_lo_q;
            4'h3: begin
              arch_q[`PSO_IDX_V0]   <= control_block_base;
              arch_q[`PSO_IDX_CONTROL_BLOCK_BASE] <= a0;
              old_page_table_base_q            <= arch_q[`PSO_IDX_PAGE_TABLE_BASE];
            end
            4'h4: arch_q[`PSO_IDX_SP]   <= mem_rd;
            4'h5: arch_q[`PSO_IDX_USP]  <= mem_rd;
            4'h6: arch_q[`PSO_IDX_PAGE_TABLE_BASE] <= mem_rd;
            4'h7: begin
              arch_q[`PSO_IDX_PCC] <= {32'h0, mem_rd[31:0] - tmp_cc_q};
              if (`PSO_ASN_IMPL) begin
                arch_q[`PSO_IDX_ASN] <= {32'h0, mem_rd[63:32]};
              end
            end
            4'h8: arch_q[`PSO_IDX_FEN] <= {63'h0, mem_rd[0]};
            4'h9: begin
              if (`PSO_UNIQ_IMPL) begin
                arch_q[`PSO_IDX_UNIQ] <= mem_rd;
              end
            end
            default: begin
              tmp_ps_q <= tmp_ps_q;
            end
          endcase
        end
        default: begin
          tmp_ps_q <= tmp_ps_q;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Stack and control block memory
  // --------------------------------------------------------------------------
  // No reset: software loads frames and control blocks before use.
  always_ff @(posedge pclk) begin
    if (apb_wr && paddr[11]) begin
      if (paddr[2]) begin
        mem_q[paddr[8:3]] <= {pwdata, mem_q[paddr[8:3]][31:0]};
      end else begin
        mem_q[paddr[8:3]] <= {mem_q[paddr[8:3]][63:32], pwdata};
      end
    end else if (state_q == pso_pkg::PSO_RUN && op_q == `PSO_OP_SWPCTX) begin
      case (step_q)
        4'h0: mem_q[pc_idx] <= sp;
        4'h1: mem_q[pc_idx + 6'h1] <= arch_q[`PSO_IDX_USP];
        4'h2: mem_q[pc_idx + 6'h3] <= {mem_q[pc_idx + 6'h3][63:32],
                                       cc_lo_q + arch_q[`PSO_IDX_PCC][31:0]};
        4'h3: begin
          if (`PSO_UNIQ_IMPL) begin
            mem_q[pc_idx + 6'h4] <= arch_q[`PSO_IDX_UNIQ];
          end
        end
        default: begin
          mem_q[0] <= mem_q[0];
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Cycle counter and flags
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_lo_q <= 32'h0;
    end else begin
      cc_lo_q <= cc_lo_q + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
      bkp_meta_q <= 1'b0;
      bkp_sync_q <= 1'b0;
    end else begin
      irq_meta_q <= irq_pin;
      irq_sync_q <= irq_meta_q;
      bkp_meta_q <= mem_only_backup;
      bkp_sync_q <= bkp_meta_q;
    end
  end

  // A new interrupt or lock in the clearing cycle is kept: set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_intr_q <= 1'b0;
      lock_q      <= 1'b0;
      fault_q     <= 1'b0;
    end else begin
      if (irq_sync_q) begin
        pend_intr_q <= 1'b1;
      end else if (fin && op_q == `PSO_OP_RTI) begin
        pend_intr_q <= 1'b0;
      end
      if (lock_set) begin
        lock_q <= 1'b1;
      end else if (fin && op_q == `PSO_OP_RTI) begin
        lock_q <= 1'b0;
      end
      if (cmd_wr && pwdata[7:0] != `PSO_OP_NONE && !start_ok) begin
        fault_q <= 1'b1;
      end else if (cmd_wr && pwdata[`PSO_CTRL_CLR_BIT]) begin
        fault_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Event outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events     <= '0;
      event_addr <= 64'h0;
      halted     <= 1'b0;
    end else begin
      events         <= '0;
      events.opfault <= cmd_wr && pwdata[7:0] != `PSO_OP_NONE && !start_ok;
      halted         <= state_q == pso_pkg::PSO_HALT
                        || (state_q == pso_pkg::PSO_RUN && step_q == 4'h0 && !kstack_ok
                        && (op_q == `PSO_OP_RTI || op_q == `PSO_OP_RETSYS));
      if (fin) begin
        case (op_q)
          `PSO_OP_CFLUSH: begin
            // Without a memory-only backup supply the flush is a no-op.
            events.dcache_page_flush <= bkp_sync_q;
            event_addr               <= a0;
          end
          `PSO_OP_CSERVE: events.console_service <= 1'b1;
          `PSO_OP_SWPPAL: begin
            if (fw_status == 2'h0) begin
              events.icache_flush <= 1'b1;
              events.tb_inval_all <= 1'b1;
              events.fw_transfer  <= 1'b1;
              event_addr          <= fw_target;
            end
          end
          `PSO_OP_SWPCTX: begin
            events.tb_inval_nonglobal <= !`PSO_ASN_IMPL
                                         && old_page_table_base_q != arch_q[`PSO_IDX_PAGE_TABLE_BASE];
          end
          default: begin
            events.fw_transfer <= 1'b0;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  // Accesses wait while an operation runs, which keeps every update atomic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (psel && penable && !pready && state_q != pso_pkg::PSO_RUN) begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= 32'h0;
      if (paddr[11] && mapped) begin
        prdata <= paddr[2] ? mem_q[paddr[8:3]][63:32] : mem_q[paddr[8:3]][31:0];
      end else if (mapped && idx == `PSO_IDX_CTRL) begin
        prdata <= paddr[2] ? 32'h0 : {20'h0, lock_q, pend_intr_q,
                  state_q == pso_pkg::PSO_HALT, fault_q, op_q};
      end else if (mapped && idx == `PSO_IDX_PCC) begin
        prdata <= paddr[2] ? arch_q[`PSO_IDX_PCC][31:0] : cc_lo_q;
      end else if (mapped) begin
        prdata <= paddr[2] ? arch_q[idx][63:32] : arch_q[idx][31:0];
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- pso_sva.sv
// Port checker of the privileged operation unit.
`timescale 1ns/10ps
`default_nettype none
module pso_sva (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [31:0]          prdata,
  input wire pso_pkg::pso_events_s events,
  input wire logic                 halted
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_err_data_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer without ready or with data");
  a_halt_sticky: assert property (halted |=> halted)
    else $error("halt released without reset");
  a_fault_alone: assert property (events.opfault |-> events[5:0] == 6'h00)
    else $error("faulting operation still produced an effect");
  a_event_pulse: assert property (events != 7'h00 |=> events == 7'h00)
    else $error("event held longer than one cycle");
  a_swap_flushes: assert property (events.fw_transfer |-> events.icache_flush
    && events.tb_inval_all) else $error("image transfer without flushes");
  a_no_nonglobal: assert property (!events.tb_inval_nonglobal)
    else $error("non-global invalidate with address spaces present");
  c_transfer: cover property (events.fw_transfer);
  c_flush: cover property (events.dcache_page_flush);
  c_halt: cover property ($rose(halted));
endmodule
bind pso_privileged_state_ops pso_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .events(events),
  .halted(halted));
`default_nettype wire

//--- tb.sv
// Self-checking bench of the privileged operation unit.
`timescale 1ns/10ps
`default_nettype none
`include "pso_regs.svh"
module tb;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                 irq_pin, backup, lock_set, halted, clr;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata;
  logic [32:0]          r;
  logic [63:0]          event_addr, v, u;
  int                   fail_count, n_compared;
  pso_pkg::pso_events_s events, seen;
  logic [4:0]           ti[4] = '{`PSO_IDX_MACHINE_CHECK_SUMMARY, `PSO_IDX_USP, `PSO_IDX_SYSVAL, `PSO_IDX_PS};
  logic [7:0]           tc[4] = '{`PSO_OP_RDMCES, `PSO_OP_RDUSP, `PSO_OP_RDVAL, `PSO_OP_RDPS};
  logic [63:0]          tv[4] = '{64'h3_0000_0011, 64'hFEDC_BA98_7654_3210,
                                  64'h0123_4567_89AB_CDEF, 64'h5};
  logic [63:0]          st[6] = '{64'hC, 64'h400, 64'h77, 64'hA0, 64'hA1, 64'hA2};
  logic [63:0]          cx[6] = '{64'h1111, 64'h2222, 64'h3333, 64'h5_0000_0000, 64'h66, 64'h1};
  logic [63:0]          pa[4] = '{64'h9, 64'h2, 64'h2, 64'h12340};
  logic [63:0]          pv[4] = '{64'h1, 64'h2, 64'h0, 64'h0};
  logic [63:0]          pe[4] = '{64'h0, 64'h0, 64'h20000, 64'h12340};

  pso_privileged_state_ops DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_pin(irq_pin), .mem_only_backup(backup), .lock_set(lock_set),
    .events(events), .event_addr(event_addr), .halted(halted));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) seen <= clr ? 7'h00 : seen | events;

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Holds the whole request until ready is sampled high, then takes the answer.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = {pslverr, prdata};
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic w64(input logic [11:0] a, input logic [63:0] d);
    apb(1'b1, a, d[31:0]);
    apb(1'b1, a | 12'h004, d[63:32]);
  endtask
  task automatic r64(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    v[31:0] = r[31:0];
    apb(1'b0, a | 12'h004, 32'h0);
    v[63:32] = r[31:0];
  endtask
  function automatic logic [11:0] ra(input logic [4:0] i);
    return {4'h0, i, 3'h0};
  endfunction
  function automatic logic [11:0] ma(input int q);
    return {3'h4, 6'(q), 3'h0};
  endfunction
  task automatic ck(input string n, input logic [11:0] a, input logic [63:0] e);
    r64(a);
    chk(n, v, e);
  endtask
  // Starts an operation; the control read after it waits for the end and leaves it in v.
  task automatic op(input logic [7:0] c);
    clr <= 1'b1;
    apb(1'b1, ra(`PSO_IDX_CTRL), {24'h0, c});
    clr <= 1'b0;
    r64(ra(`PSO_IDX_CTRL));
  endtask

  initial begin
    {presetn, psel, penable, pwrite, irq_pin, backup, lock_set} = 7'h00;
    {paddr, pwdata, fail_count, n_compared, clr} = 1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    ck("ps_reset", ra(`PSO_IDX_PS), 64'h0);
    apb(1'b0, 12'h0A0, 32'h0);
    chk("unmapped", 64'(r), 64'h1_0000_0000);
    for (int k = 0; k < 4; k++) begin
      w64(ra(ti[k]), tv[k]);
      op(tc[k]);
      ck("read_op", ra(`PSO_IDX_V0), tv[k]);
    end
    w64(ra(`PSO_IDX_A0), 64'h0B);
    op(`PSO_OP_SWPIPL);
    ck("ipl_old", ra(`PSO_IDX_V0), 64'h5);
    ck("ipl_new", ra(`PSO_IDX_PS), 64'h3);
    op(`PSO_OP_CSERVE);
    chk("cserve", 64'(seen.console_service), 64'h1);
    w64(ra(`PSO_IDX_A0), 64'h55);
    // No other memory traffic surrounds a flush, which stands in for the barriers.
    op(`PSO_OP_CFLUSH);
    chk("flush_none", 64'(seen.dcache_page_flush), 64'h0);
    backup <= 1'b1;
    repeat (4) @(posedge pclk);
    op(`PSO_OP_CFLUSH);
    chk("flush", 64'(seen.dcache_page_flush), 64'h1);
    chk("flush_pfn", event_addr, 64'h55);
    w64(ra(`PSO_IDX_V0), 64'hAB);
    w64(ra(`PSO_IDX_PS), 64'h8);
    for (int c = 1; c < 12; c++) begin
      op(8'(c));
      chk("user_fault", 64'(seen.opfault), 64'h1);
    end
    chk("fault_sticky", 64'(v[8]), 64'h1);
    ck("fault_v0", ra(`PSO_IDX_V0), 64'hAB);
    apb(1'b1, ra(`PSO_IDX_CTRL), 32'h100);
    w64(ra(`PSO_IDX_PS), 64'h0);
    w64(ra(`PSO_IDX_SP), 64'h100);
    w64(ra(`PSO_IDX_USP), 64'h50);
    for (int k = 0; k < 6; k++) w64(ma(32 + k), st[k]);
    lock_set <= 1'b1;
    irq_pin  <= 1'b1;
    @(posedge pclk);
    lock_set <= 1'b0;
    repeat (4) @(posedge pclk);
    irq_pin <= 1'b0;
    r64(ra(`PSO_IDX_CTRL));
    chk("flags_set", 64'(v[11:8]), 64'hC);
    op(`PSO_OP_RTI);
    chk("flags_clr", 64'(v[11:10]), 64'h0);
    ck("rti_ps", ra(`PSO_IDX_PS), 64'h8);
    ck("rti_pc", ra(`PSO_IDX_PC), 64'h400);
    ck("rti_a2", ra(`PSO_IDX_A2), 64'hA2);
    ck("rti_ksp", ra(`PSO_IDX_KSP), 64'h130);
    ck("rti_sp", ra(`PSO_IDX_SP), 64'h50);
    w64(ra(`PSO_IDX_PS), 64'h0);
    w64(ra(`PSO_IDX_SP), 64'h80);
    w64(ra(`PSO_IDX_USP), 64'h60);
    w64(ma(17), 64'h480);
    w64(ma(18), 64'h78);
    op(`PSO_OP_RETSYS);
    ck("sys_pc", ra(`PSO_IDX_PC), 64'h480);
    ck("sys_gp", ra(`PSO_IDX_GP), 64'h78);
    ck("sys_ksp", ra(`PSO_IDX_KSP), 64'hB0);
    ck("sys_ps", ra(`PSO_IDX_PS), 64'h8);
    w64(ra(`PSO_IDX_PS), 64'h0);
    w64(ra(`PSO_IDX_CONTROL_BLOCK_BASE), 64'h40);
    w64(ra(`PSO_IDX_SP), 64'hAA);
    w64(ra(`PSO_IDX_USP), 64'hBB);
    w64(ra(`PSO_IDX_A0), 64'h100);
    for (int k = 0; k < 6; k++) w64(ma(32 + k), cx[k]);
    op(`PSO_OP_SWPCTX);
    chk("ctx_no_inval", 64'(seen.tb_inval_nonglobal), 64'h0);
    ck("ctx_old", ra(`PSO_IDX_V0), 64'h40);
    ck("ctx_base", ra(`PSO_IDX_CONTROL_BLOCK_BASE), 64'h100);
    ck("ctx_sp", ra(`PSO_IDX_SP), 64'h1111);
    ck("ctx_ptb", ra(`PSO_IDX_PAGE_TABLE_BASE), 64'h3333);
    ck("ctx_fen", ra(`PSO_IDX_FEN), 64'h1);
    ck("ctx_asn", ra(`PSO_IDX_ASN), 64'h5);
    ck("ctx_uniq", ra(`PSO_IDX_UNIQ), 64'h66);
    ck("ctx_save", ma(9), 64'hBB);
    r64(ma(11));
    u = v;
    r64(ra(`PSO_IDX_PCC));
    chk("ctx_cc", 64'(32'(u[31:0] + v[63:32])), 64'h0);
    for (int k = 0; k < 4; k++) begin
      w64(ra(`PSO_IDX_FWLD), k > 1 ? 64'h4 : 64'h0);
      w64(ra(`PSO_IDX_A0), pa[k]);
      op(`PSO_OP_SWPPAL);
      ck("pal_status", ra(`PSO_IDX_V0), pv[k]);
      chk("pal_go", 64'(seen.fw_transfer && seen.icache_flush && seen.tb_inval_all),
          64'(k > 1));
      if (k > 1) chk("pal_entry", event_addr, pe[k]);
    end
    w64(ra(`PSO_IDX_SP), 64'h104);
    op(`PSO_OP_RETSYS);
    chk("halt", 64'({halted, v[9]}), 64'h3);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("halt_reset", 64'(halted), 64'h0);
    end_sim;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    end_sim;
  end
endmodule
`default_nettype wire
